// file: rtl/codec_frame_pkg.sv
// package of constants for the codec serial frame timing core
package codec_frame_pkg;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // control_reg_one fields
  localparam int ENABLE_BIT = 15;
  localparam int CLKGEN_BIT = 14;
  localparam int DIR_BIT = 8;
  localparam int MODE_LSB = 0;
  // control_reg_two fields
  localparam int WS_LSB = 0;
  localparam int FCOUNT_LSB = 4;
  localparam int DIV_LSB = 8;
  localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h000f;
  localparam logic [7:0] ACLINK_FRAME_CLOCKS = 8'hff;
  localparam logic [7:0] ACLINK_SYNC_HIGH = 8'h10;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0]
  {
    MODE_MULTI = 2'b00,
    MODE_I2S = 2'b01,
    MODE_AC16 = 2'b10,
    MODE_AC20 = 2'b11
  } frame_mode_e;
endpackage

// file: rtl/codec_bit_clock_gen.sv
// bit clock divider producing a link-rate enable and the bit clock level
`timescale 1ns/1ps
`default_nettype none
module codec_bit_clock_gen #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // control
  input wire logic run_in,
  input wire logic [DIV_W-1:0] half_period_in,
  // outputs
  output logic level_out,
  output logic fall_out
);
  logic [DIV_W-1:0] count_q;

  // a stopped generator holds all counters at zero
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || !run_in)
    begin
      count_q <= '0;
      level_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else if (count_q >= half_period_in)
    begin
      count_q <= '0;
      level_out <= ~level_out;
      fall_out <= level_out;
    end
    else
    begin
      count_q <= count_q + 1'b1;
      fall_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/codec_frame_timing.sv
// codec interface frame timing core with ahb-lite register access
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module codec_frame_timing #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // bit clock pin
  input wire logic bit_clock_pin_in,
  output logic bit_clock_pin_out,
  output logic bit_clock_pin_oe_n_out,
  // frame sync pin
  input wire logic frame_sync_pin_in,
  output logic frame_sync_pin_out,
  output logic frame_sync_pin_oe_n_out,
  // serial data
  output logic serial_data_in_oe_n_out,
  output logic serial_data_out_oe_n_out,
  // frame start marker for the data path
  output logic frame_start_out
);
  typedef codec_frame_pkg::frame_mode_e frame_mode_e_t;

  logic [15:0] control_reg_one_q;
  logic [15:0] control_reg_two_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic enable;
  logic clkgen_on;
  logic slave_mode;
  frame_mode_e_t mode;
  logic [3:0] word_size_field;
  logic [3:0] frame_count_field;
  logic [DIV_W-1:0] half_period;
  logic gen_level;
  logic gen_fall;
  logic [codec_frame_pkg::SYNC_STAGES-1:0] sck_sync_q;
  logic [codec_frame_pkg::SYNC_STAGES-1:0] fs_sync_q;
  logic sck_prev_q;
  logic fs_prev_q;
  logic bit_tick;
  logic fs_rise;
  logic [3:0] word_cnt_q;
  logic [3:0] frame_cnt_q;
  logic [7:0] ac_cnt_q;
  logic [3:0] word_last;
  logic [3:0] frame_last;
  logic word_wrap;
  logic frame_wrap;
  logic fs_d;

  assign enable = control_reg_one_q[codec_frame_pkg::ENABLE_BIT];
  assign clkgen_on = control_reg_one_q[codec_frame_pkg::CLKGEN_BIT];
  assign slave_mode = control_reg_one_q[codec_frame_pkg::DIR_BIT];
  assign mode = frame_mode_e_t'(control_reg_one_q[codec_frame_pkg::MODE_LSB +: 2]);
  assign word_size_field = control_reg_two_q[codec_frame_pkg::WS_LSB +: 4];
  assign frame_count_field = control_reg_two_q[codec_frame_pkg::FCOUNT_LSB +: 4];
  assign half_period = control_reg_two_q[codec_frame_pkg::DIV_LSB +: DIV_W];

  // ahb-lite: writes land in the data phase, reads answer with zero wait
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (hready_in)
    begin
      wr_pend_q <= hsel_in && htrans_in[1] && hwrite_in;
      wr_addr_q <= haddr_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      control_reg_one_q <= codec_frame_pkg::CONTROL_ONE_RESET;
      control_reg_two_q <= codec_frame_pkg::CONTROL_TWO_RESET;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == codec_frame_pkg::ADDR_CONTROL_ONE)
        control_reg_one_q <= hwdata_in[15:0];
      if (wr_addr_q == codec_frame_pkg::ADDR_CONTROL_TWO)
        control_reg_two_q <= hwdata_in[15:0];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      hrdata_out <= 32'h0000_0000;
    else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
    begin
      case (haddr_in)
        codec_frame_pkg::ADDR_CONTROL_ONE: hrdata_out <= {16'h0000, control_reg_one_q};
        codec_frame_pkg::ADDR_CONTROL_TWO: hrdata_out <= {16'h0000, control_reg_two_q};
        codec_frame_pkg::ADDR_STATUS: hrdata_out <= {20'h00000, frame_cnt_q, word_cnt_q, 3'h0, frame_sync_pin_out};
        default: hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // generator runs with the block or alone for the bit clock pin only
  codec_bit_clock_gen #(
    .DIV_W(DIV_W)
  ) u_clkgen (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .run_in(enable || clkgen_on),
    .half_period_in(half_period),
    .level_out(gen_level),
    .fall_out(gen_fall)
  );

  // pin inputs pass two flops; edge detection looks only at the second
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      sck_sync_q <= '0;
      fs_sync_q <= '0;
      sck_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end
    else
    begin
      sck_sync_q <= {sck_sync_q[0], bit_clock_pin_in};
      fs_sync_q <= {fs_sync_q[0], frame_sync_pin_in};
      sck_prev_q <= sck_sync_q[1];
      fs_prev_q <= fs_sync_q[1];
    end
  end

  // as slave the codec also supplies the bit clock; counters step on its falling edge
  assign bit_tick = enable && (slave_mode ? (sck_prev_q && !sck_sync_q[1]) : gen_fall);
  assign fs_rise = slave_mode && fs_sync_q[1] && !fs_prev_q;

  // ac-link frame is sixteen full words, so frame starts never follow the count field
  always_comb
  begin
    word_last = word_size_field;
    frame_last = frame_count_field;
    if (mode == codec_frame_pkg::MODE_AC16 || mode == codec_frame_pkg::MODE_AC20)
    begin
      word_last = 4'hf;
      frame_last = 4'hf;
    end
  end

  assign word_wrap = (word_cnt_q == word_last);
  assign frame_wrap = word_wrap && (frame_cnt_q == frame_last);

  // word and frame counters; cleared whenever the block is disabled
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || !enable)
    begin
      word_cnt_q <= 4'h0;
      frame_cnt_q <= 4'h0;
      ac_cnt_q <= 8'h00;
    end
    else if (fs_rise)
    begin
      word_cnt_q <= 4'h0;
      frame_cnt_q <= 4'h0;
      ac_cnt_q <= 8'h00;
    end
    else if (bit_tick)
    begin
      word_cnt_q <= word_wrap ? 4'h0 : word_cnt_q + 4'h1;
      if (word_wrap)
        frame_cnt_q <= frame_wrap ? 4'h0 : frame_cnt_q + 4'h1;
      ac_cnt_q <= ac_cnt_q + 8'h01;
    end
  end

  // frame sync level from the counter positions
  always_comb
  begin
    case (mode)
      codec_frame_pkg::MODE_MULTI: fs_d = (word_cnt_q == 4'h0) && (frame_cnt_q == 4'h0);
      codec_frame_pkg::MODE_I2S: fs_d = frame_cnt_q[0];
      codec_frame_pkg::MODE_AC16: fs_d = (ac_cnt_q < codec_frame_pkg::ACLINK_SYNC_HIGH);
      codec_frame_pkg::MODE_AC20: fs_d = (ac_cnt_q < codec_frame_pkg::ACLINK_SYNC_HIGH);
      default: fs_d = 1'b0;
    endcase
  end

  // pin drive: disabled block releases all pins except a lone bit clock
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      bit_clock_pin_out <= 1'b0;
      bit_clock_pin_oe_n_out <= 1'b1;
      frame_sync_pin_out <= 1'b0;
      frame_sync_pin_oe_n_out <= 1'b1;
      serial_data_in_oe_n_out <= 1'b1;
      serial_data_out_oe_n_out <= 1'b1;
      frame_start_out <= 1'b0;
    end
    else
    begin
      bit_clock_pin_out <= gen_level;
      bit_clock_pin_oe_n_out <= !((enable && !slave_mode) || (!enable && clkgen_on));
      frame_sync_pin_out <= enable && !slave_mode && fs_d;
      frame_sync_pin_oe_n_out <= !(enable && !slave_mode);
      serial_data_in_oe_n_out <= 1'b1;
      serial_data_out_oe_n_out <= !enable;
      frame_start_out <= fs_rise || (enable && !slave_mode && bit_tick && frame_wrap);
    end
  end

  // assertions
  frame_reset_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !enable |=> (word_cnt_q == 4'h0) && (frame_cnt_q == 4'h0) && (ac_cnt_q == 8'h00))
    else $error("counters not cleared while disabled");
  clock_stop_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!enable && !clkgen_on) |=> !gen_level && !gen_fall)
    else $error("bit clock generator running while disabled");
  pin_owner_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    enable |=> !serial_data_out_oe_n_out)
    else $error("data out pin not owned while enabled");
  clk_alone_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!enable && clkgen_on) |=> !bit_clock_pin_oe_n_out && frame_sync_pin_oe_n_out)
    else $error("lone bit clock drive wrong");
  word_count_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (enable && bit_tick && !fs_rise && !word_wrap) |=> word_cnt_q == $past(word_cnt_q) + 4'h1)
    else $error("word counter did not step");
  ac_ignore_ws_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (enable && bit_tick && !fs_rise && word_cnt_q != 4'hf
      && (mode == codec_frame_pkg::MODE_AC16 || mode == codec_frame_pkg::MODE_AC20))
      |=> word_cnt_q == $past(word_cnt_q) + 4'h1)
    else $error("word size used in ac-link");
  frame_step_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (enable && bit_tick && !fs_rise && word_wrap && !frame_wrap) |=> frame_cnt_q == $past(frame_cnt_q) + 4'h1)
    else $error("frame counter did not step");
  ac_sync_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (enable && !slave_mode && mode == codec_frame_pkg::MODE_AC16 && ac_cnt_q == 8'h10) |=> !frame_sync_pin_out)
    else $error("ac-link sync high too long");
  slave_restart_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (enable && fs_rise) |=> (word_cnt_q == 4'h0) && (frame_cnt_q == 4'h0) && frame_start_out)
    else $error("slave restart missed");
endmodule
`default_nettype wire

// file: verification/codec_model.sv
// behavioural codec that drives bit clock and frame sync as frame master
`timescale 1ns/1ps
`default_nettype none
module codec_model #(
  parameter int FRAME_BITS = 16
) (
  // control
  input wire logic run_in,
  // link outputs
  output logic bclk_out,
  output logic fsync_out
);
  int cnt;
  initial
  begin
    bclk_out = 1'b0;
    fsync_out = 1'b0;
    forever
    begin
      wait (run_in);
      // odd offset keeps the link phase unrelated to the system clock
      #1.3;
      cnt = 0;
      while (run_in)
      begin
        fsync_out = (cnt == 0);
        #40 bclk_out = 1'b1;
        #40 bclk_out = 1'b0;
        cnt = (cnt + 1) % FRAME_BITS;
      end
      // released line shows the inverse level so a stale value cannot pass
      fsync_out = ~fsync_out;
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the codec frame timing core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic codec_run = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, bck_o, bck_oe_n, fs_o, fs_oe_n, sdi_oe_n, sdo_oe_n, fstart, codec_bck, codec_fs;
  wire logic bck_wire = bck_oe_n ? codec_bck : bck_o;
  wire logic fs_wire = fs_oe_n ? codec_fs : fs_o;
  int num_errors = 0;
  int compares = 0;
  logic [31:0] rd;
  int hi, per, gap;
  codec_frame_timing i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .bit_clock_pin_in(bck_wire),
    .bit_clock_pin_out(bck_o), .bit_clock_pin_oe_n_out(bck_oe_n), .frame_sync_pin_in(fs_wire),
    .frame_sync_pin_out(fs_o), .frame_sync_pin_oe_n_out(fs_oe_n), .serial_data_in_oe_n_out(sdi_oe_n),
    .serial_data_out_oe_n_out(sdo_oe_n), .frame_start_out(fstart));
  codec_model #(.FRAME_BITS(16)) i_codec (.run_in(codec_run), .bclk_out(codec_bck), .fsync_out(codec_fs));
  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do
      @(posedge clk_sys_in);
    while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do
      @(posedge clk_sys_in);
    while (hready !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [31:0] c1(logic en, logic gen, logic dir, logic [1:0] mode);
    c1 = 32'h0;
    c1[codec_frame_pkg::ENABLE_BIT] = en;
    c1[codec_frame_pkg::CLKGEN_BIT] = gen;
    c1[codec_frame_pkg::DIR_BIT] = dir;
    c1[1:0] = mode;
  endfunction
  // half period field 1 gives a bit clock of four system cycles
  function automatic logic [31:0] c2(logic [3:0] ws, logic [3:0] fc);
    c2 = {16'h0000, 8'h01, fc, ws};
  endfunction
  task automatic cfg(input logic [31:0] v2, input logic [31:0] v1);
    ahb(1'b1, codec_frame_pkg::ADDR_CONTROL_ONE, 32'h0, rd);
    ahb(1'b1, codec_frame_pkg::ADDR_CONTROL_TWO, v2, rd);
    ahb(1'b1, codec_frame_pkg::ADDR_CONTROL_ONE, v1, rd);
  endtask
  // measured on the falling system edge where registered outputs are settled
  // in multichannel and ac-link modes the first high level after enable is one cycle longer than the rest, so it is skipped
  task automatic sync_shape(output int h, output int p);
    h = 0;
    while (fs_o !== 1'b1) @(negedge clk_sys_in);
    while (fs_o !== 1'b0) @(negedge clk_sys_in);
    while (fs_o !== 1'b1) @(negedge clk_sys_in);
    while (fs_o === 1'b1)
    begin
      h++;
      @(negedge clk_sys_in);
    end
    p = h;
    while (fs_o === 1'b0)
    begin
      p++;
      @(negedge clk_sys_in);
    end
  endtask
  task automatic pulse_gap(output int g);
    while (fstart !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    g = 1;
    while (fstart !== 1'b1)
    begin
      g++;
      @(negedge clk_sys_in);
    end
  endtask
  task automatic t_reset();
    ahb(1'b0, codec_frame_pkg::ADDR_CONTROL_ONE, 32'h0, rd);
    chk(rd, 32'h0000_0000, "control one reset");
    ahb(1'b0, codec_frame_pkg::ADDR_CONTROL_TWO, 32'h0, rd);
    chk(rd, 32'h0000_000f, "control two reset");
    ahb(1'b1, 8'h0c, 32'hffff_ffff, rd);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    chk(hresp, 1'b0, "okay response");
    chk({bck_oe_n, fs_oe_n, sdo_oe_n, sdi_oe_n}, 4'hf, "pins released");
    $display("reset test done");
  endtask
  task automatic t_multi();
    cfg(c2(4'h3, 4'h2), c1(1'b1, 1'b0, 1'b0, codec_frame_pkg::MODE_MULTI));
    sync_shape(hi, per);
    chk(hi, 4, "multichannel sync width");
    chk(per, 48, "multichannel frame");
    pulse_gap(gap);
    chk(gap, 48, "frame start spacing");
    chk({bck_oe_n, fs_oe_n, sdo_oe_n, sdi_oe_n}, 4'h1, "pins owned");
    $display("multichannel test done");
  endtask
  task automatic t_i2s();
    for (int w = 7; w < 16; w += 8)
    begin
      cfg(c2(w[3:0], 4'h1), c1(1'b1, 1'b0, 1'b0, codec_frame_pkg::MODE_I2S));
      sync_shape(hi, per);
      chk(hi, 4 * (w + 1), "i2s high level");
      chk(per, 8 * (w + 1), "i2s period");
    end
    $display("i2s test done");
  endtask
  task automatic t_aclink();
    for (int m = 2; m < 4; m++)
    begin
      cfg(c2(4'h3, 4'h2), c1(1'b1, 1'b0, 1'b0, m[1:0]));
      sync_shape(hi, per);
      chk(hi, 64, "ac-link sync high");
      chk(per, 1024, "ac-link frame");
    end
    $display("ac-link test done");
  endtask
  task automatic t_disable();
    ahb(1'b1, codec_frame_pkg::ADDR_CONTROL_ONE, 32'h0, rd);
    repeat (40) @(posedge clk_sys_in);
    ahb(1'b0, codec_frame_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd[11:4], 8'h00, "counters cleared");
    repeat (40) @(posedge clk_sys_in);
    ahb(1'b0, codec_frame_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd[11:0], 12'h000, "counters held");
    chk({bck_oe_n, fs_oe_n}, 2'h3, "pins released");
    $display("disable test done");
  endtask
  task automatic t_clkgen();
    int n;
    logic last;
    cfg(c2(4'h3, 4'h0), c1(1'b0, 1'b1, 1'b0, codec_frame_pkg::MODE_MULTI));
    repeat (8) @(negedge clk_sys_in);
    n = 0;
    last = bck_o;
    repeat (40)
    begin
      @(negedge clk_sys_in);
      n += (bck_o !== last);
      last = bck_o;
    end
    chk(n, 20, "generator alone toggles");
    chk({bck_oe_n, fs_oe_n}, 2'h1, "only bit clock driven");
    $display("clock generator test done");
  endtask
  task automatic t_slave();
    cfg(c2(4'h3, 4'h3), c1(1'b1, 1'b0, 1'b1, codec_frame_pkg::MODE_MULTI));
    codec_run <= 1'b1;
    pulse_gap(gap);
    pulse_gap(gap);
    chk(gap, 320, "slave frame follows codec");
    chk({bck_oe_n, fs_oe_n}, 2'h3, "sync taken from codec");
    codec_run <= 1'b0;
    ahb(1'b1, codec_frame_pkg::ADDR_CONTROL_ONE, 32'h0, rd);
    $display("slave test done");
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_multi();
    t_i2s();
    t_aclink();
    t_disable();
    t_clkgen();
    t_slave();
    wrap_up();
  end
endmodule
`default_nettype wire
